// *** bench/motor_model.sv ***
// behavioural motor at the far side: hall pattern and phase currents
`timescale 1ns/100ps
module motor_model (
   input  wire        clk_sys_i,   // system clock
   input  wire [2:0]  hall_set_i,  // hall state to present, U at bit 0
   input  wire [15:0] amp_i,       // phase current level
   output reg  [2:0]  hall_o,      // hall pins U,V,W
   output reg  [15:0] cur_u_o,     // sampled U current
   output reg  [15:0] cur_v_o,     // sampled V current
   output reg  [15:0] cur_w_o      // sampled W current
);
   // phases differ by one count so a swapped phase shows up
   always @(posedge clk_sys_i) begin
      hall_o  <= hall_set_i;
      cur_u_o <= amp_i;
      cur_v_o <= amp_i + 16'h0001;
      cur_w_o <= amp_i + 16'h0002;
   end
endmodule

// *** bench/servo_fb_monitor.sv ***
// concurrent checks on the ports of the feedback configuration block
`timescale 1ns/100ps
`include "servo_fb_defs.vh"
module servo_fb_monitor (
   input wire        clk_sys_i,      // system clock
   input wire        nrst_i,         // async reset, active low
   input wire        wr_i,           // write strobe
   input wire        rd_i,           // read strobe
   input wire [15:0] rdata_o,        // read data
   input wire        power_cycle_i,  // settings latch pulse
   input wire [15:0] cur_u_i,        // sampled U current
   input wire [15:0] cur_u_o,        // effective U current
   input wire [1:0]  vel_method_o,   // velocity method
   input wire        comm_active_o,  // search running
   input wire [15:0] comm_current_o, // search current
   input wire        comm_done_o,    // angle known
   input wire        servo_on_i,     // servo on pin
   input wire        homing_done_i,  // homing finished
   input wire        home_move_o,    // move by offset
   input wire        dir_o,          // rotation direction
   input wire [15:0] pole_pitch_o    // active pole pitch
);
   reg [1:0] age_reg;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   // age since reset release, so history checks skip reset-time samples
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) age_reg <= 2'h0;
      else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
   end
   ////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data not zero outside read slot");
   ofs_steady_a: assert property (
      age_reg == 2'h3 && !$past(wr_i) && !$past(wr_i, 2) |->
      (cur_u_o - $past(cur_u_i)) == ($past(cur_u_o) - $past(cur_u_i, 2)))
      else $error("U offset changed without a write");
   vel_range_a: assert property (vel_method_o != 2'd3)
      else $error("velocity method outside 0 to 2");
   comm_cur_a: assert property (
      comm_active_o |-> comm_current_o <= `COMM_CURRENT_MAX)
      else $error("commutation current above limit");
   comm_idle_a: assert property (
      !comm_active_o |-> comm_current_o == 16'h0000)
      else $error("commutation current outside run");
   done_quiet_a: assert property (
      comm_done_o |-> !comm_active_o)
      else $error("search running after angle known");
   comm_start_a: assert property ($rose(comm_active_o) |->
      $past(servo_on_i, 2) || $past(servo_on_i, 3) || $past(servo_on_i, 4))
      else $error("search started without servo on");
   move_pulse_a: assert property (
      home_move_o |-> $past(homing_done_i) ##1 !home_move_o)
      else $error("home move not a single pulse after homing");
   dir_cause_a: assert property ($changed(dir_o) |->
      $past(wr_i, 2) || $past(power_cycle_i, 2))
      else $error("direction changed without cause");
   pitch_hold_a: assert property ($changed(pole_pitch_o) |->
      $past(power_cycle_i) || $past(wr_i) || $past(wr_i, 2))
      else $error("pole pitch changed without power cycle");
endmodule
bind servo_fb_config servo_fb_monitor u_mon (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .power_cycle_i(power_cycle_i), .cur_u_i(cur_u_i),
   .cur_u_o(cur_u_o), .vel_method_o(vel_method_o),
   .comm_active_o(comm_active_o), .comm_current_o(comm_current_o),
   .comm_done_o(comm_done_o), .servo_on_i(servo_on_i),
   .homing_done_i(homing_done_i), .home_move_o(home_move_o),
   .dir_o(dir_o), .pole_pitch_o(pole_pitch_o));

// *** bench/testbench.sv ***
// self-checking bench for the feedback configuration block
`timescale 1ns/100ps
`include "servo_fb_defs.vh"
module testbench;
   reg         clk_sys_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   reg  [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, amp = 16'h0064;
   reg  [15:0] home_offset_i = 16'h0123, rd_v;
   reg         power_cycle_i = 1'b0, small_drive_i = 1'b0;
   reg         servo_on_i = 1'b0, homing_done_i = 1'b0;
   reg  [2:0]  hall_set = 3'b001;
   wire [15:0] cur_u_i, cur_v_i, cur_w_i, cur_u_o, cur_v_o, cur_w_o;
   wire [15:0] rdata_o, comm_current_o, pole_pitch_o, scale_res_o;
   wire [15:0] grating_o, zero_pos_o;
   wire [2:0]  hall_i, hall_o;
   wire [1:0]  vel_method_o;
   wire        hall_single_o, dir_o, comm_active_o, comm_done_o, home_move_o;
   integer     n_errors = 0, checked = 0, i, j;
   reg  [15:0] dflt [0:8];
   reg  [15:0] cfgs [0:9];
   always #12.5 clk_sys_i = ~clk_sys_i;
   servo_fb_config u_servo_fb_config (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .power_cycle_i(power_cycle_i),
      .small_drive_i(small_drive_i), .cur_u_i(cur_u_i), .cur_v_i(cur_v_i),
      .cur_w_i(cur_w_i), .cur_u_o(cur_u_o), .cur_v_o(cur_v_o),
      .cur_w_o(cur_w_o), .hall_i(hall_i), .hall_o(hall_o),
      .hall_single_o(hall_single_o), .dir_o(dir_o), .servo_on_i(servo_on_i),
      .comm_active_o(comm_active_o), .comm_current_o(comm_current_o),
      .comm_done_o(comm_done_o), .pole_pitch_o(pole_pitch_o),
      .scale_res_o(scale_res_o), .grating_o(grating_o),
      .vel_method_o(vel_method_o), .homing_done_i(homing_done_i),
      .home_offset_i(home_offset_i), .home_move_o(home_move_o),
      .zero_pos_o(zero_pos_o));
   motor_model u_motor_model (.clk_sys_i(clk_sys_i), .hall_set_i(hall_set),
      .amp_i(amp), .hall_o(hall_i), .cur_u_o(cur_u_i), .cur_v_o(cur_v_i),
      .cur_w_o(cur_w_i));
   ////////////////////////////////////////////////////////////////////////
   // bus cycles and helpers; reads sample just after the answer lands
   task tick(input integer n); begin
      repeat (n) @(posedge clk_sys_i);
      #1;
   end endtask
   task wr(input [15:0] a, input [15:0] d); begin
      @(posedge clk_sys_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_sys_i); wr_i <= 1'b0;
   end endtask
   task rd(input [15:0] a); begin
      @(posedge clk_sys_i); addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_sys_i); rd_i <= 1'b0;
      #1 rd_v = rdata_o;
   end endtask
   task pulse_pc; begin
      @(posedge clk_sys_i); power_cycle_i <= 1'b1;
      @(posedge clk_sys_i); power_cycle_i <= 1'b0;
      tick(5);
   end endtask
   task cmp(input string nm, input [15:0] e, input [15:0] g); begin
      checked = checked + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   end endtask
   // hall conditioning: inversion first, then swaps UV, VW, WU in turn
   function [2:0] hexp(input [2:0] r, input [15:0] c);
      reg [2:0] h;
      begin
         h = r ^ {c[10], c[9], c[8]};
         if (c[12]) h = {h[2], h[0], h[1]};
         if (c[13]) h = {h[1], h[2], h[0]};
         if (c[14]) h = {h[0], h[1], h[2]};
         hexp = h;
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task t_reset; begin
      dflt = '{`RST_POLE_PITCH, `RST_SCALE_RES, `RST_COMM_METHOD,
         `RST_COMM_CURRENT, `RST_COMM_TIME, `RST_GRATING_PERIOD,
         `RST_HOMING_DONE, `RST_VEL_METHOD, `RST_HALL_CONFIG};
      for (i = 0; i < 9; i = i + 1) begin
         rd(`ADDR_POLE_PITCH + i);
         cmp("default", dflt[i], rd_v);
      end
      rd(16'h2040); cmp("unmapped", 16'h0000, rd_v);
      cmp("pitch_out", 16'h0960, pole_pitch_o);
      cmp("res_out", 16'h03E8, scale_res_o);
      cmp("grating_out", 16'h0028, grating_o);
      cmp("done_m0", 16'h0001, comm_done_o);
   end endtask
   // offsets subtract; the strap drops the W offset unless forced large
   task t_offset; begin
      wr(`ADDR_PHASE_OFS_U, 16'h0005); wr(`ADDR_PHASE_OFS_V, 16'h0007);
      wr(`ADDR_PHASE_OFS_W, 16'h0009); tick(3);
      cmp("cur_u", 16'h005F, cur_u_o);
      cmp("cur_v", 16'h005E, cur_v_o);
      cmp("cur_w", 16'h005D, cur_w_o);
      small_drive_i <= 1'b1; tick(5);
      cmp("cur_w_small", 16'h0066, cur_w_o);
      wr(`ADDR_CTRL, 16'h0002); tick(3);
      cmp("cur_w_large", 16'h005D, cur_w_o);
      wr(`ADDR_CTRL, 16'h0000);
   end endtask
   task t_power; begin
      wr(`ADDR_POLE_PITCH, 16'h1234); wr(`ADDR_SCALE_RES, 16'h0200);
      wr(`ADDR_GRATING_PERIOD, 16'h0014); tick(3);
      cmp("pitch_held", 16'h0960, pole_pitch_o);
      rd(`ADDR_POLE_PITCH); cmp("pitch_reg", 16'h1234, rd_v);
      pulse_pc;
      cmp("pitch_new", 16'h1234, pole_pitch_o);
      cmp("res_new", 16'h0200, scale_res_o);
      cmp("grat_new", 16'h0014, grating_o);
   end endtask
   task t_clamp; begin
      wr(`ADDR_COMM_CURRENT, 16'h07D0); rd(`ADDR_COMM_CURRENT);
      cmp("cur_clamp", `COMM_CURRENT_MAX, rd_v);
      wr(`ADDR_COMM_TIME, 16'h0064); rd(`ADDR_COMM_TIME);
      cmp("time_low", `COMM_TIME_MIN, rd_v);
      wr(`ADDR_COMM_TIME, 16'h2000); rd(`ADDR_COMM_TIME);
      cmp("time_high", `COMM_TIME_MAX, rd_v);
   end endtask
   // code 3 is outside the documented set and falls back to 0
   task t_vel; begin
      for (i = 0; i < 4; i = i + 1) begin
         wr(`ADDR_VEL_METHOD, i); tick(2);
         cmp("vel", (i == 3) ? 16'h0000 : i, vel_method_o);
      end
   end endtask
   task t_hall; begin
      cfgs = '{16'h0000, 16'h0100, 16'h0200, 16'h0400, 16'h1000,
         16'h2000, 16'h4000, 16'h08FE, 16'h8000, 16'h0001};
      for (j = 0; j < 2; j = j + 1) begin
         hall_set <= j ? 3'b011 : 3'b001;
         for (i = 0; i < 10; i = i + 1) begin
            wr(`ADDR_HALL_CONFIG, cfgs[i]); pulse_pc;
            cmp("hall", hexp(hall_set, cfgs[i]), hall_o);
            cmp("single", cfgs[i][15], hall_single_o);
            cmp("dir", cfgs[i][0], dir_o);
         end
      end
      wr(`ADDR_CTRL, 16'h0001); tick(3);
      cmp("dir_xor", 16'h0000, dir_o);
      wr(`ADDR_CTRL, 16'h0000);
   end endtask
   task t_home(input [15:0] mode); begin
      wr(`ADDR_HOMING_DONE, mode); tick(1);
      @(posedge clk_sys_i); homing_done_i <= 1'b1;
      @(posedge clk_sys_i); homing_done_i <= 1'b0; #1;
      cmp("zero_pos", mode[0] ? 16'h0000 : 16'h0123, zero_pos_o);
      cmp("move", mode[0], home_move_o);
      tick(1); cmp("move_end", 16'h0000, home_move_o);
   end endtask
   // methods 0 and 2 never start a search on servo on; method 1 does
   task t_comm; begin
      wr(`ADDR_COMM_METHOD, 16'h0002); pulse_pc;
      servo_on_i <= 1'b1; tick(8);
      cmp("no_search", 16'h0000, comm_active_o);
      cmp("done_kept", 16'h0001, comm_done_o);
      servo_on_i <= 1'b0; wr(`ADDR_COMM_METHOD, 16'h0001); pulse_pc;
      cmp("wait_son", 16'h0000, comm_active_o);
      servo_on_i <= 1'b1; tick(4);
      cmp("search", 16'h0001, comm_active_o);
      cmp("search_cur", `COMM_CURRENT_MAX, comm_current_o);
      cmp("search_done", 16'h0000, comm_done_o);
      rd(`ADDR_STATUS); cmp("status", 16'h0009, rd_v);
   end endtask
   // a reset in mid search drops it and restores the boot settings
   task t_rerst; begin
      servo_on_i <= 1'b0; nrst_i <= 1'b0; tick(2);
      cmp("rst_active", 16'h0000, comm_active_o);
      nrst_i <= 1'b1; tick(2);
      cmp("rst_done", 16'h0001, comm_done_o);
      cmp("rst_pitch", `RST_POLE_PITCH, pole_pitch_o);
      cmp("rst_dir", 16'h0000, dir_o);
   end endtask
   ////////////////////////////////////////////////////////////////////////
   task summarize; begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   end endtask
   initial begin
      tick(12); nrst_i <= 1'b1; tick(2);
      t_reset; t_offset; t_power; t_clamp; t_vel; t_hall;
      t_home(16'h0000); t_home(16'h0001); t_comm; t_rerst;
      summarize;
   end
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(25 * 20000);
      n_errors = n_errors + 1;
      summarize;
   end
endmodule

// *** common/servo_fb_defs.vh ***
// constants for the motor feedback and commutation configuration block
`ifndef SERVO_FB_DEFS_VH
`define SERVO_FB_DEFS_VH
// register word addresses
`define ADDR_PHASE_OFS_U     16'h2015
`define ADDR_PHASE_OFS_V     16'h2016
`define ADDR_PHASE_OFS_W     16'h2017
`define ADDR_POLE_PITCH      16'h2018
`define ADDR_SCALE_RES       16'h2019
`define ADDR_COMM_METHOD     16'h201A
`define ADDR_COMM_CURRENT    16'h201B
`define ADDR_COMM_TIME       16'h201C
`define ADDR_GRATING_PERIOD  16'h201D
`define ADDR_HOMING_DONE     16'h201E
`define ADDR_VEL_METHOD      16'h201F
`define ADDR_HALL_CONFIG     16'h2020
`define ADDR_CTRL            16'h2030
`define ADDR_STATUS          16'h2031
// reset values
`define RST_POLE_PITCH       16'h0960
`define RST_SCALE_RES        16'h03E8
`define RST_COMM_METHOD      16'h0000
`define RST_COMM_CURRENT     16'h01F4
`define RST_COMM_TIME        16'h03E8
`define RST_GRATING_PERIOD   16'h0028
`define RST_HOMING_DONE      16'h0000
`define RST_VEL_METHOD       16'h0000
`define RST_HALL_CONFIG      16'h0000
// limits
`define COMM_CURRENT_MAX     16'h03E8
`define COMM_TIME_MIN        16'h01F4
`define COMM_TIME_MAX        16'h1388
// hall configuration bit positions
`define HALL_DIR_BIT         0
`define HALL_INV_U_BIT       8
`define HALL_INV_V_BIT       9
`define HALL_INV_W_BIT       10
`define HALL_SWAP_UV_BIT     12
`define HALL_SWAP_VW_BIT     13
`define HALL_SWAP_WU_BIT     14
`define HALL_SINGLE_BIT      15
// control register bit positions
`define CTRL_DIR_BIT         0
`define CTRL_LARGE_BIT       1
`define CTRL_APPLY_BIT       2
// timing: one millisecond at 40 MHz
`define CLK_FREQ_HZ          40000000
`define TIME_MS_UNIT         1
`define CYCLES_PER_MS        (`CLK_FREQ_HZ / 1000 * `TIME_MS_UNIT)
`endif

// *** src/servo_fb_config.v ***
// motor feedback, commutation and hall configuration with register port
//
// How it works
// - effective phase current is sampled current minus configured offset
// - small drives (7.5kW or less) ignore the W phase offset unless control bit 1 forces large
// - pole pitch in 0.01 mm spans one electrical cycle, default 2400
// - scale resolution is in nanometres, default 1000 for 1 um scale
// - method 0 hall or none, 1 commutate at first servo on, 2 reserved
// - commutation current in 0.1 percent steps, 0 to 1000, default 500
// - commutation runs for programmed ms, 500 to 5000, default 1000
// - grating period in micrometres, default 40, is encoder grid size
// - homing mode 0: no motion, home offset becomes zero position
// - homing mode 1: move by home offset, zero position becomes 0
// - velocity method 0 MT plus observer, 1 MT, 2 M method
// - hall bit 0 sets direction, xored with the separate direction bit
// - hall bits 8, 9, 10 invert U, V, W hall inputs before decoding
// - hall bits 12, 13, 14 swap U/V, V/W, W/U before decoding
// - hall bit 15 selects single ended hall reception
`timescale 1ns/100ps
`include "servo_fb_defs.vh"

module servo_fb_config (
   input  wire        clk_sys_i,          // 40 MHz system clock
   input  wire        nrst_i,             // async reset, active low
   input  wire [15:0] addr_i,             // register word address
   input  wire [15:0] wdata_i,            // write data
   input  wire        wr_i,               // write strobe
   input  wire        rd_i,               // read strobe
   output reg  [15:0] rdata_o,            // read data, cycle after rd_i
   input  wire        power_cycle_i,      // pulse: latch power cycle params
   input  wire        small_drive_i,      // strap: 7.5kW or lower rating
   input  wire [15:0] cur_u_i,            // sampled U current, signed
   input  wire [15:0] cur_v_i,            // sampled V current, signed
   input  wire [15:0] cur_w_i,            // sampled W current, signed
   output reg  [15:0] cur_u_o,            // effective U current
   output reg  [15:0] cur_v_o,            // effective V current
   output reg  [15:0] cur_w_o,            // effective W current
   input  wire [2:0]  hall_i,             // raw hall pins U,V,W at bit 0,1,2
   output reg  [2:0]  hall_o,             // conditioned hall state
   output reg         hall_single_o,      // single ended hall reception
   output reg         dir_o,              // effective rotation direction
   input  wire        servo_on_i,         // servo on request, pin level
   output reg         comm_active_o,      // initial angle search running
   output reg  [15:0] comm_current_o,     // commutation current, 0.1 percent
   output reg         comm_done_o,        // initial angle known
   output reg  [15:0] pole_pitch_o,       // active pole pitch, 0.01 mm
   output reg  [15:0] scale_res_o,        // active scale resolution, nm
   output reg  [15:0] grating_o,          // active grating period, um
   output reg  [1:0]  vel_method_o,       // velocity estimation method
   input  wire        homing_done_i,      // pulse: homing finished
   input  wire [15:0] home_offset_i,      // home offset value
   output reg         home_move_o,        // pulse: move by home offset
   output reg  [15:0] zero_pos_o          // zero position
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_DONE = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // software registers
   reg  [15:0] ofs_u_reg, ofs_v_reg, ofs_w_reg;
   reg  [15:0] pitch_reg, res_reg, method_reg, ccur_reg, ctime_reg;
   reg  [15:0] grat_reg, homing_reg, vel_reg, hall_reg, ctrl_reg;
   // power cycle shadows, steering the logic
   reg  [15:0] method_act_reg, hall_act_reg;
   reg  [1:0]  state_reg;
   reg  [15:0] ms_cnt_reg;
   reg  [31:0] cyc_cnt_reg;
   reg  [2:0]  hall_s1_reg, hall_s2_reg;
   reg         son_s1_reg, son_s2_reg, small_s1_reg, small_s2_reg;
   reg  [2:0]  hall_inv;
   reg  [2:0]  hall_sw;

   // clamp the commutation time into its legal window
   function [15:0] clamp_time;
      input [15:0] t;
      begin
         if (t < `COMM_TIME_MIN)
            clamp_time = `COMM_TIME_MIN;
         else if (t > `COMM_TIME_MAX)
            clamp_time = `COMM_TIME_MAX;
         else
            clamp_time = t;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register writes; out of range current and time are clamped here
   // so the search never sees an illegal setting
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ofs_u_reg  <= 16'h0000;
         ofs_v_reg  <= 16'h0000;
         ofs_w_reg  <= 16'h0000;
         pitch_reg  <= `RST_POLE_PITCH;
         res_reg    <= `RST_SCALE_RES;
         method_reg <= `RST_COMM_METHOD;
         ccur_reg   <= `RST_COMM_CURRENT;
         ctime_reg  <= `RST_COMM_TIME;
         grat_reg   <= `RST_GRATING_PERIOD;
         homing_reg <= `RST_HOMING_DONE;
         vel_reg    <= `RST_VEL_METHOD;
         hall_reg   <= `RST_HALL_CONFIG;
         ctrl_reg   <= 16'h0000;
      end else if (wr_i) begin
         if (addr_i == `ADDR_PHASE_OFS_U)
            ofs_u_reg <= wdata_i;
         else if (addr_i == `ADDR_PHASE_OFS_V)
            ofs_v_reg <= wdata_i;
         else if (addr_i == `ADDR_PHASE_OFS_W)
            ofs_w_reg <= wdata_i;
         else if (addr_i == `ADDR_POLE_PITCH)
            pitch_reg <= wdata_i;
         else if (addr_i == `ADDR_SCALE_RES)
            res_reg <= wdata_i;
         else if (addr_i == `ADDR_COMM_METHOD)
            method_reg <= wdata_i;
         else if (addr_i == `ADDR_COMM_CURRENT)
            ccur_reg <= (wdata_i > `COMM_CURRENT_MAX) ?
                        `COMM_CURRENT_MAX : wdata_i;
         else if (addr_i == `ADDR_COMM_TIME)
            ctime_reg <= clamp_time(wdata_i);
         else if (addr_i == `ADDR_GRATING_PERIOD)
            grat_reg <= wdata_i;
         else if (addr_i == `ADDR_HOMING_DONE)
            homing_reg <= wdata_i;
         else if (addr_i == `ADDR_VEL_METHOD)
            vel_reg <= wdata_i;
         else if (addr_i == `ADDR_HALL_CONFIG)
            hall_reg <= wdata_i;
         else if (addr_i == `ADDR_CTRL)
            ctrl_reg <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads, data valid the cycle after the strobe
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         if (addr_i == `ADDR_PHASE_OFS_U)
            rdata_o <= ofs_u_reg;
         else if (addr_i == `ADDR_PHASE_OFS_V)
            rdata_o <= ofs_v_reg;
         else if (addr_i == `ADDR_PHASE_OFS_W)
            rdata_o <= ofs_w_reg;
         else if (addr_i == `ADDR_POLE_PITCH)
            rdata_o <= pitch_reg;
         else if (addr_i == `ADDR_SCALE_RES)
            rdata_o <= res_reg;
         else if (addr_i == `ADDR_COMM_METHOD)
            rdata_o <= method_reg;
         else if (addr_i == `ADDR_COMM_CURRENT)
            rdata_o <= ccur_reg;
         else if (addr_i == `ADDR_COMM_TIME)
            rdata_o <= ctime_reg;
         else if (addr_i == `ADDR_GRATING_PERIOD)
            rdata_o <= grat_reg;
         else if (addr_i == `ADDR_HOMING_DONE)
            rdata_o <= homing_reg;
         else if (addr_i == `ADDR_VEL_METHOD)
            rdata_o <= vel_reg;
         else if (addr_i == `ADDR_HALL_CONFIG)
            rdata_o <= hall_reg;
         else if (addr_i == `ADDR_CTRL)
            rdata_o <= ctrl_reg;
         // status: [1:0] search state, bit 2 angle known, bit 3 strap
         else if (addr_i == `ADDR_STATUS)
            rdata_o <= {12'h000, small_s2_reg, comm_done_o,
                        state_reg};
         else
            rdata_o <= 16'h0000;   // unmapped reads as zero
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // synchronisers for pin inputs; hall lines and the strap are not
   // related to the system clock, so two stages guard the decoding
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hall_s1_reg  <= 3'h0;
         hall_s2_reg  <= 3'h0;
         son_s1_reg   <= 1'b0;
         son_s2_reg   <= 1'b0;
         small_s1_reg <= 1'b0;
         small_s2_reg <= 1'b0;
      end else begin
         hall_s1_reg  <= hall_i;
         hall_s2_reg  <= hall_s1_reg;
         son_s1_reg   <= servo_on_i;
         son_s2_reg   <= son_s1_reg;
         small_s1_reg <= small_drive_i;
         small_s2_reg <= small_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power cycle shadows: these settings only move on a power cycle, or
   // on reset, so a running motor never sees its geometry change;
   // the apply bit copies every cycle, a bring-up aid that bypasses
   // the power cycle and must stay low in normal running
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pole_pitch_o   <= `RST_POLE_PITCH;
         scale_res_o    <= `RST_SCALE_RES;
         grating_o      <= `RST_GRATING_PERIOD;
         method_act_reg <= `RST_COMM_METHOD;
         hall_act_reg   <= `RST_HALL_CONFIG;
      end else if (power_cycle_i || ctrl_reg[`CTRL_APPLY_BIT]) begin
         pole_pitch_o   <= pitch_reg;
         scale_res_o    <= res_reg;
         grating_o      <= grat_reg;
         method_act_reg <= method_reg;
         hall_act_reg   <= hall_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase currents with offset removal; results wrap modulo 2^16,
   // so software keeps offsets inside the sensor range
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cur_u_o <= 16'h0000;
         cur_v_o <= 16'h0000;
         cur_w_o <= 16'h0000;
      end else begin
         cur_u_o <= cur_u_i - ofs_u_reg;
         cur_v_o <= cur_v_i - ofs_v_reg;
         // large drive flag comes from strap or software bit
         if (small_s2_reg && !ctrl_reg[`CTRL_LARGE_BIT])
            cur_w_o <= cur_w_i;
         else
            cur_w_o <= cur_w_i - ofs_w_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // hall conditioning: invert first, then swap pairs; bits 1-7, 11 unused
   // later swaps act on the result of earlier ones, so order matters
   always @* begin
      hall_inv = hall_s2_reg ^ {hall_act_reg[`HALL_INV_W_BIT],
                                hall_act_reg[`HALL_INV_V_BIT],
                                hall_act_reg[`HALL_INV_U_BIT]};
      hall_sw = hall_inv;
      if (hall_act_reg[`HALL_SWAP_UV_BIT])
         hall_sw = {hall_sw[2], hall_sw[0], hall_sw[1]};
      if (hall_act_reg[`HALL_SWAP_VW_BIT])
         hall_sw = {hall_sw[1], hall_sw[2], hall_sw[0]};
      if (hall_act_reg[`HALL_SWAP_WU_BIT])
         hall_sw = {hall_sw[0], hall_sw[1], hall_sw[2]};
   end

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hall_o        <= 3'h0;
         hall_single_o <= 1'b0;
         dir_o         <= 1'b0;
         vel_method_o  <= 2'h0;
      end else begin
         hall_o        <= hall_sw;
         hall_single_o <= hall_act_reg[`HALL_SINGLE_BIT];
         dir_o         <= hall_act_reg[`HALL_DIR_BIT] ^
                          ctrl_reg[`CTRL_DIR_BIT];
         // values above 2 fall back to the observer method
         vel_method_o  <= (vel_reg[15:2] == 14'h0000 && vel_reg[1:0] != 2'h3)
                          ? vel_reg[1:0] : 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // initial angle commutation at first servo on, method 1 only;
   // time is read at start; a mid-run write reaches no search, since ST_DONE holds until reset, which reloads the default;
   // the millisecond prescaler makes even the shortest search last
   // 20 million clocks, so the bench only watches it start
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg      <= ST_IDLE;
         ms_cnt_reg     <= 16'h0000;
         cyc_cnt_reg    <= 32'h00000000;
         comm_active_o  <= 1'b0;
         comm_done_o    <= 1'b0;
         comm_current_o <= 16'h0000;
      end else begin
         case (state_reg)
         ST_IDLE: begin
            if (method_act_reg != 16'h0001) begin
               comm_done_o <= 1'b1;
            end else if (son_s2_reg) begin
               state_reg      <= ST_RUN;
               ms_cnt_reg     <= ctime_reg;
               cyc_cnt_reg    <= `CYCLES_PER_MS - 1;
               comm_active_o  <= 1'b1;
               comm_current_o <= ccur_reg;
               // a new search means the angle is no longer known
               comm_done_o    <= 1'b0;
            end
         end
         ST_RUN: begin
            if (cyc_cnt_reg != 32'h00000000) begin
               cyc_cnt_reg <= cyc_cnt_reg - 32'h00000001;
            end else if (ms_cnt_reg == 16'h0001) begin
               state_reg      <= ST_DONE;
               comm_active_o  <= 1'b0;
               comm_done_o    <= 1'b1;
               comm_current_o <= 16'h0000;
            end else begin
               ms_cnt_reg  <= ms_cnt_reg - 16'h0001;
               cyc_cnt_reg <= `CYCLES_PER_MS - 1;
            end
         end
         default: begin
            state_reg <= ST_DONE;   // only once per power on
         end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // homing completion behaviour
   // only bit 0 of the setting counts; upper bits are ignored
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         home_move_o <= 1'b0;
         zero_pos_o  <= 16'h0000;
      end else begin
         home_move_o <= 1'b0;
         if (homing_done_i) begin
            if (homing_reg[0]) begin
               home_move_o <= 1'b1;
               zero_pos_o  <= 16'h0000;
            end else begin
               zero_pos_o  <= home_offset_i;
            end
         end
      end
   end

endmodule
